// ---- hdl/qfhp_device.sv ----
/*
  Device end of the quad framer host port: parallel (multiplexed or not,
  two strobe styles) and serial register access routed to one of four
  transceivers, plus the open-drain alert line.
  Assumes pins synchronous to clk and transceivers that return read data
  combinationally for reg_raddr.
*/
// Overview of operation
// - alert pulled low while any enabled status
// - board straps bus kind pins
// - unit select routes access to one transceiver
// - timing style pin picks strobe convention
// - non-multiplexed: bus data, address from pins
// - multiplexed: bus carries address then data
// - multiplexed: low address pins ignored, tied low
// - multiplexed: address taken on latch strobe rise
// - non-multiplexed: latch strobe is address msb
// - select low throughout each access
// - strobes active low, multiplexed data strobe high
// - write strobe low-active, serial data input
// - bus msb serial out, read strobe clock
// - sample edge select picks input edge
// - launch edge select picks output edge
// - bus kind decode of the two straps
// - serial command byte lsb first, burst
// - select low rise/fall input, fall/rise output
// - select high aborts, releases serial output
`timescale 1ns/1ps
`default_nettype none

module qfhp_device
(
  input  wire logic                                        clk,
  input  wire logic                                        rstn,
  qfhp_if.device                                           link,
  input  wire logic [qfhp_pkg::UNITS-1:0]                  unit_alert,
  output logic      [qfhp_pkg::AW-1:0]                     reg_raddr,
  input  wire logic [qfhp_pkg::UNITS-1:0][qfhp_pkg::DW-1:0] reg_rdata,
  output logic      [qfhp_pkg::UNITS-1:0]                  reg_we,
  output logic      [qfhp_pkg::AW-1:0]                     reg_waddr,
  output logic      [qfhp_pkg::DW-1:0]                     reg_wdata
);
  import qfhp_pkg::*;

  typedef enum logic [2:0] {
    S_IDLE  = 3'h0,
    S_CMD   = 3'h1,
    S_WDATA = 3'h3,
    S_RDATA = 3'h5,
    S_DONE  = 3'h7
  } qfhp_ser_type;

  typedef struct packed {
    qfhp_ser_type     st;
    logic             sclk;
    logic             ale;
    logic             act;
    logic [AW-1:0]    addr;
    logic [DW-1:0]    sh;
    logic [2:0]       cnt;
    logic             burst;
    logic [DW-1:0]    dout;
    logic             serial_out;
    logic             sdo_oe;
    logic             par_oe;
    logic [UNITS-1:0] we;
    logic [AW-1:0]    waddr;
    logic [DW-1:0]    wdata;
    logic             alert;
  } qfhp_dev_type;

  localparam qfhp_dev_type DEV_RST = '0;

  ////////////////////////////////////////////////////////////////////////////
  // helpers
  function automatic logic [UNITS-1:0] qfhp_onehot(input logic [UW-1:0] u);
    logic [UNITS-1:0] v;
    v    = '0;
    v[u] = 1'b1;
    return v;
  endfunction : qfhp_onehot
  function automatic logic [AW-1:0] qfhp_next(input logic [AW-1:0] a);
    logic [LAW-1:0] lo;
    lo = a[LAW-1:0] + 1'b1;
    return {1'b0, lo};
  endfunction : qfhp_next

  ////////////////////////////////////////////////////////////////////////////
  // decode and next state
  qfhp_dev_type  q;
  qfhp_dev_type  d;
  qfhp_kind_type kind;
  logic [UW-1:0] unit;
  logic          cs;
  logic          serial_in;
  logic          rise;
  logic          fall;
  logic          samp;
  logic          launch;
  logic          ds_style;
  logic          is_wr;
  logic          act;
  logic          ale_rise;
  logic [AW-1:0] paddr;
  logic [AW-1:0] raddr;
  logic [DW-1:0] cmd;
  logic [2:0]    nxt;

  always_comb
  begin
    kind     = qfhp_kind_type'({link.bus_kind_sel_hi,
                                link.bus_kind_sel_lo});
    unit     = {link.unit_sel_hi, link.unit_sel_lo};
    cs       = ~link.cs_n;
    serial_in      = link.write_strobe_n;
    rise     = link.read_strobe_n & ~q.sclk;
    fall     = ~link.read_strobe_n & q.sclk;
    samp     = link.sample_edge_sel ? fall : rise;
    launch   = link.launch_edge_sel ? rise : fall;
    ds_style = link.parallel_timing_style;
    is_wr    = ~link.write_strobe_n;
    if (ds_style)
      act = (kind == K_MUX) ? link.read_strobe_n
                            : ~link.read_strobe_n;
    else
      act = ~link.read_strobe_n | is_wr;
    act      = act & cs & ~kind[1];
    ale_rise = link.addr_latch_strobe & ~q.ale;
    if (kind == K_MUX)
      paddr = ale_rise ? link.shared_addr_data_bus[AW-1:0]
                       : q.addr;
    else
      paddr = {link.addr_latch_strobe,
               link.low_addr_inputs};
    cmd      = {serial_in, q.sh[DW-1:1]};
    nxt      = q.cnt;
    raddr    = q.addr;

    d        = q;
    d.we     = '0;
    d.sclk   = link.read_strobe_n;
    d.ale    = link.addr_latch_strobe;
    d.act    = act;
    d.par_oe = 1'b0;
    d.alert  = (|unit_alert) & (kind != K_TEST);

    if (!cs || kind == K_TEST)
    begin
      // abort any transfer, release the pins
      d.st     = S_IDLE;
      d.cnt    = '0;
      d.sdo_oe = 1'b0;
    end
    else if (kind == K_SERIAL)
    begin
      unique case (q.st)
        S_IDLE:
        begin
          d.st  = S_CMD;
          d.cnt = '0;
        end
        S_CMD:
        begin
          if (samp)
          begin
            d.sh  = cmd;
            d.cnt = q.cnt + 1'b1;
            if (q.cnt == SER_LAST)
            begin
              d.addr  = {1'b0, cmd[CMD_ADDR_MSB:CMD_ADDR_LSB]};
              d.burst = cmd[CMD_BURST_BIT];
              raddr   = {1'b0, cmd[CMD_ADDR_MSB:CMD_ADDR_LSB]};
              if (cmd[CMD_RD_BIT])
              begin
                d.st     = S_RDATA;
                d.dout   = reg_rdata[unit];
                d.serial_out    = reg_rdata[unit][0];
                d.sdo_oe = 1'b1;
              end
              else
                d.st = S_WDATA;
            end
          end
        end
        S_WDATA:
        begin
          if (samp)
          begin
            d.sh  = cmd;
            d.cnt = q.cnt + 1'b1;
            if (q.cnt == SER_LAST)
            begin
              d.we    = qfhp_onehot(unit);
              d.waddr = q.addr;
              d.wdata = cmd;
              if (q.burst)
                d.addr = qfhp_next(q.addr);
              else
                d.st = S_DONE;
            end
          end
        end
        S_RDATA:
        begin
          if (samp)
          begin
            nxt = q.cnt + 1'b1;
            if (q.cnt == SER_LAST)
            begin
              if (q.burst)
              begin
                d.addr = qfhp_next(q.addr);
                raddr  = qfhp_next(q.addr);
                d.dout = reg_rdata[unit];
              end
              else
                d.st = S_DONE;
            end
          end
          d.cnt = nxt;
          if (launch)
            d.serial_out = d.dout[nxt];
        end
        S_DONE: d.st = S_DONE;
      endcase
    end
    else
    begin
      // parallel access
      d.st = S_IDLE;
      if (kind == K_MUX && ale_rise)
        d.addr = paddr;
      raddr = paddr;
      if (act && !is_wr)
      begin
        d.par_oe = 1'b1;
        d.dout   = reg_rdata[unit];
      end
      if (act && !q.act && is_wr)
      begin
        d.we    = qfhp_onehot(unit);
        d.waddr = paddr;
        d.wdata = link.shared_addr_data_bus;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      q <= DEV_RST;
    else
      q <= d;
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs
  assign reg_raddr        = raddr;
  assign reg_we           = q.we;
  assign reg_waddr        = q.waddr;
  assign reg_wdata        = q.wdata;
  assign link.alert_oe    = q.alert;
  assign link.bus_dev_out = q.sdo_oe ? {q.serial_out, {SDO_BIT{1'b0}}}
                                     : q.dout;
  assign link.bus_dev_oe  = {q.sdo_oe, {SDO_BIT{1'b0}}}
                          | {DW{q.par_oe}};
endmodule : qfhp_device

`default_nettype wire

// ---- hdl/qfhp_pkg.sv ----
/*
  Shared constants and types for the quad framer host port: bus kinds,
  serial command byte layout, controller registers and sequencing codes.
  Assumes nothing of its surroundings.
*/
`default_nettype none

package qfhp_pkg;
  localparam int AW    = 6;
  localparam int LAW   = 5;
  localparam int DW    = 8;
  localparam int UNITS = 4;
  localparam int UW    = 2;

  ////////////////////////////////////////////////////////////////////////////
  // bus kind straps {hi, lo}
  typedef enum logic [1:0] {
    K_MUX    = 2'h0,
    K_NONMUX = 2'h1,
    K_SERIAL = 2'h2,
    K_TEST   = 2'h3
  } qfhp_kind_type;

  ////////////////////////////////////////////////////////////////////////////
  // serial command byte, lsb first
  localparam int         SDO_BIT       = 7;
  localparam int         CMD_RD_BIT    = 0;
  localparam int         CMD_ADDR_LSB  = 1;
  localparam int         CMD_ADDR_MSB  = 5;
  localparam int         CMD_RSV_BIT   = 6;
  localparam int         CMD_BURST_BIT = 7;
  localparam logic [2:0] SER_LAST      = 3'h7;

  ////////////////////////////////////////////////////////////////////////////
  // controller registers
  localparam logic [2:0] HR_CTRL   = 3'h0;
  localparam logic [2:0] HR_ADDR   = 3'h1;
  localparam logic [2:0] HR_WDATA  = 3'h2;
  localparam logic [2:0] HR_CMD    = 3'h3;
  localparam logic [2:0] HR_STATUS = 3'h4;
  localparam logic [2:0] HR_RDATA  = 3'h5;
  localparam int CTRL_W          = 7;
  localparam int CTRL_KIND_LSB   = 0;
  localparam int CTRL_STYLE_BIT  = 2;
  localparam int CTRL_SAMP_BIT   = 3;
  localparam int CTRL_LAUNCH_BIT = 4;
  localparam int CTRL_UNIT_LSB   = 5;
  localparam int GO_WR_BIT       = 0;
  localparam int GO_RD_BIT       = 1;
  localparam int ST_BUSY_BIT     = 0;
  localparam int ST_DONE_BIT     = 1;
  localparam int ST_ALERT_BIT    = 2;

  ////////////////////////////////////////////////////////////////////////////
  // controller sequencing
  localparam logic [5:0] PAR_LAST  = 6'h03;
  localparam logic [5:0] SER_END   = 6'h3f;
  localparam logic [1:0] P_ADDR    = 2'h0;
  localparam logic [1:0] P_STROBE  = 2'h1;
  localparam logic [1:0] P_WAIT    = 2'h2;
  localparam logic [1:0] P_CAP     = 2'h3;
  localparam logic [1:0] T_DATA    = 2'h0;
  localparam logic [1:0] T_FIRST   = 2'h1;
  localparam logic [1:0] T_SECOND  = 2'h3;
  localparam int         SER_TICK_DEF = 4;
endpackage : qfhp_pkg

`default_nettype wire

// ---- hdl/qfhp_if.sv ----
/*
  Pin carrier between the host controller and the device port.
  Resolves the shared bus (pulled high when undriven) from the output
  enables of both ends, and the open-drain alert line from the device's.
*/
`timescale 1ns/1ps
`default_nettype none

interface qfhp_if;
  logic                        cs_n;
  logic                        bus_kind_sel_lo;
  logic                        bus_kind_sel_hi;
  logic                        parallel_timing_style;
  logic                        unit_sel_lo;
  logic                        unit_sel_hi;
  logic                        sample_edge_sel;
  logic                        launch_edge_sel;
  logic [qfhp_pkg::LAW-1:0]    low_addr_inputs;
  logic                        addr_latch_strobe;
  logic                        read_strobe_n;
  logic                        write_strobe_n;
  logic [qfhp_pkg::DW-1:0]     bus_host_out;
  logic                        bus_host_oe;
  logic [qfhp_pkg::DW-1:0]     bus_dev_out;
  logic [qfhp_pkg::DW-1:0]     bus_dev_oe;
  logic                        alert_oe;
  logic [qfhp_pkg::DW-1:0]     shared_addr_data_bus;
  logic                        alert_n;

  // per pin: device, then host, else pull-up
  always_comb
  begin
    for (int i = 0; i < qfhp_pkg::DW; i++)
    begin
      if (bus_dev_oe[i])
        shared_addr_data_bus[i] = bus_dev_out[i];
      else if (bus_host_oe)
        shared_addr_data_bus[i] = bus_host_out[i];
      else
        shared_addr_data_bus[i] = 1'b1;
    end
  end

  assign alert_n = ~alert_oe;

  modport device (
    input  cs_n, bus_kind_sel_lo, bus_kind_sel_hi, parallel_timing_style,
    input  unit_sel_lo, unit_sel_hi, sample_edge_sel, launch_edge_sel,
    input  low_addr_inputs, addr_latch_strobe, read_strobe_n,
    input  write_strobe_n, shared_addr_data_bus,
    output bus_dev_out, bus_dev_oe, alert_oe
  );

  modport host (
    output cs_n, bus_kind_sel_lo, bus_kind_sel_hi, parallel_timing_style,
    output unit_sel_lo, unit_sel_hi, sample_edge_sel, launch_edge_sel,
    output low_addr_inputs, addr_latch_strobe, read_strobe_n,
    output write_strobe_n, bus_host_out, bus_host_oe,
    input  shared_addr_data_bus, alert_n
  );
endinterface : qfhp_if

`default_nettype wire

// ---- hdl/qfhp_host.sv ----
/*
  Host end of the quad framer host port: a bus master that straps the
  device and runs one register read or write per command, parallel or
  serial, under control of its own small register set.
  Assumes a software port with one-cycle strobes and a device on link.
*/
`timescale 1ns/1ps
`default_nettype none

module qfhp_host
#(
  parameter int SER_TICK = qfhp_pkg::SER_TICK_DEF
)
(
  input  wire logic                     clk,
  input  wire logic                     rstn,
  qfhp_if.host                          link,
  input  wire logic [2:0]               sw_addr,
  input  wire logic [qfhp_pkg::DW-1:0]  sw_wdata,
  input  wire logic                     sw_wr,
  input  wire logic                     sw_rd,
  output logic      [qfhp_pkg::DW-1:0]  sw_rdata
);
  import qfhp_pkg::*;

  if (SER_TICK < 1)
    $error("SER_TICK must be at least 1");

  localparam int            TW    = $clog2(SER_TICK + 1);
  localparam logic [TW-1:0] TLAST = TW'(SER_TICK - 1);

  typedef enum logic [1:0] {
    H_IDLE = 2'h0,
    H_RUN  = 2'h1,
    H_END  = 2'h3
  } qfhp_hst_type;

  typedef struct packed {
    qfhp_hst_type    st;
    logic [CTRL_W-1:0] ctrl;
    logic [AW-1:0]   addr;
    logic [DW-1:0]   wdata;
    logic [DW-1:0]   rdata;
    logic            wr;
    logic            done;
    logic [5:0]      seq;
    logic [TW-1:0]   tdiv;
    logic [DW-1:0]   rsp;
    logic            cs_n;
    logic            rs_n;
    logic            ws_n;
    logic            ale;
    logic [LAW-1:0]  low;
    logic [DW-1:0]   bout;
    logic            boe;
  } qfhp_host_type;

  // select and strobes idle high in reset
  function automatic qfhp_host_type qfhp_host_rst();
    qfhp_host_type r;
    r      = '0;
    r.cs_n = 1'b1;
    r.rs_n = 1'b1;
    r.ws_n = 1'b1;
    return r;
  endfunction : qfhp_host_rst

  localparam qfhp_host_type HOST_RST = qfhp_host_rst();

  qfhp_host_type q;
  qfhp_host_type d;
  qfhp_kind_type kind;
  logic          moto;
  logic          idle_rs;
  logic [15:0]   frame;
  logic [3:0]    bitn;

  ////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb
  begin
    kind    = qfhp_kind_type'(q.ctrl[CTRL_KIND_LSB +: 2]);
    moto    = q.ctrl[CTRL_STYLE_BIT];
    idle_rs = ~(moto && kind == K_MUX);
    frame   = {q.wdata, 1'b0, 1'b0, q.addr[LAW-1:0], ~q.wr};
    bitn    = q.seq[5:2];
    d       = q;
    d.rsp   = '0;

    if (sw_rd)
    begin
      unique case (sw_addr)
        HR_CTRL:   d.rsp = DW'(q.ctrl);
        HR_ADDR:   d.rsp = DW'(q.addr);
        HR_WDATA:  d.rsp = q.wdata;
        HR_STATUS: d.rsp = DW'({~link.alert_n, q.done, q.st != H_IDLE});
        HR_RDATA:  d.rsp = q.rdata;
        default:   d.rsp = '0;
      endcase
      if (sw_addr == HR_STATUS)
        d.done = 1'b0;
    end
    if (sw_wr && q.st == H_IDLE)
    begin
      unique case (sw_addr)
        HR_CTRL:  d.ctrl  = sw_wdata[CTRL_W-1:0];
        HR_ADDR:  d.addr  = sw_wdata[AW-1:0];
        HR_WDATA: d.wdata = sw_wdata;
        HR_CMD:
        begin
          if (sw_wdata[GO_WR_BIT] || sw_wdata[GO_RD_BIT])
          begin
            d.st   = H_RUN;
            d.wr   = sw_wdata[GO_WR_BIT];
            d.seq  = '0;
            d.tdiv = '0;
            d.cs_n = 1'b0;
          end
        end
        default: d.st = q.st;
      endcase
    end

    unique case (q.st)
      H_IDLE:
      begin
        d.rs_n = idle_rs;
        d.ws_n = 1'b1;
        d.ale  = 1'b0;
        d.low  = '0;
      end
      H_RUN:
      begin
        if (kind == K_SERIAL)
        begin
          d.tdiv = q.tdiv + 1'b1;
          if (q.tdiv == TLAST)
          begin
            d.tdiv = '0;
            d.seq  = q.seq + 1'b1;
            if (q.seq == SER_END)
              d.st = H_END;
            if (q.seq[1:0] == T_DATA)
              d.ws_n = frame[bitn];
            if (q.seq[1:0] == T_FIRST)
              d.rs_n = 1'b0;
            if (q.seq[1:0] == T_SECOND)
              d.rs_n = 1'b1;
            if (bitn[3] && !q.wr
                && ((q.seq[1:0] == T_FIRST && q.ctrl[CTRL_SAMP_BIT])
                 || (q.seq[1:0] == T_SECOND && !q.ctrl[CTRL_SAMP_BIT])))
              d.rdata[bitn[2:0]] = link.shared_addr_data_bus[SDO_BIT];
          end
        end
        else
        begin
          d.seq = q.seq + 1'b1;
          if (q.seq == PAR_LAST)
            d.st = H_END;
          unique case (q.seq[1:0])
            P_ADDR:
            begin
              if (kind == K_MUX)
              begin
                d.bout = DW'(q.addr);
                d.boe  = 1'b1;
                d.ale  = 1'b1;
              end
              else
              begin
                d.low = q.addr[LAW-1:0];
                d.ale = q.addr[AW-1];
              end
              d.ws_n = moto ? ~q.wr : 1'b1;
            end
            P_STROBE:
            begin
              if (kind == K_MUX)
                d.ale = 1'b0;
              d.bout = q.wdata;
              d.boe  = q.wr;
              if (moto)
                d.rs_n = ~idle_rs;
              else if (q.wr)
                d.ws_n = 1'b0;
              else
                d.rs_n = 1'b0;
            end
            P_WAIT:
              d.seq = q.seq + 1'b1;
            P_CAP:
            begin
              if (!q.wr)
                d.rdata = link.shared_addr_data_bus;
            end
          endcase
        end
      end
      H_END:
      begin
        d.cs_n = 1'b1;
        d.rs_n = idle_rs;
        d.ws_n = 1'b1;
        d.boe  = 1'b0;
        d.done = 1'b1;
        d.st   = H_IDLE;
      end
      default: d.st = H_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      q <= HOST_RST;
    else
      q <= d;
  end

  ////////////////////////////////////////////////////////////////////////////
  // pins

  assign sw_rdata                   = q.rsp;
  assign link.cs_n                  = ~rstn | q.cs_n;
  assign link.bus_kind_sel_lo       = q.ctrl[CTRL_KIND_LSB];
  assign link.bus_kind_sel_hi       = q.ctrl[CTRL_KIND_LSB + 1];
  assign link.parallel_timing_style = q.ctrl[CTRL_STYLE_BIT];
  assign link.sample_edge_sel       = q.ctrl[CTRL_SAMP_BIT];
  assign link.launch_edge_sel       = q.ctrl[CTRL_LAUNCH_BIT];
  assign link.unit_sel_lo           = q.ctrl[CTRL_UNIT_LSB];
  assign link.unit_sel_hi           = q.ctrl[CTRL_UNIT_LSB + 1];
  assign link.low_addr_inputs       = q.low;
  assign link.addr_latch_strobe     = q.ale;
  assign link.read_strobe_n         = q.rs_n;
  assign link.write_strobe_n        = q.ws_n;
  assign link.bus_host_out          = q.bout;
  assign link.bus_host_oe           = q.boe;
endmodule : qfhp_host

`default_nettype wire

// ---- test/qfhp_properties.sv ----
/*
  Pin-level checks of the device end of the host port.
  Assumes interface signals on one clock and async low reset.
*/
`timescale 1ns/1ps
`default_nettype none

module qfhp_properties
(
  input wire logic                    clk,
  input wire logic                    rstn,
  input wire logic                    cs_n,
  input wire logic                    bus_kind_sel_lo,
  input wire logic                    bus_kind_sel_hi,
  input wire logic                    parallel_timing_style,
  input wire logic                    read_strobe_n,
  input wire logic                    write_strobe_n,
  input wire logic [qfhp_pkg::DW-1:0] bus_dev_oe,
  input wire logic                    alert_oe
);
  logic par;
  logic ser;
  logic tst;
  assign par = !bus_kind_sel_hi;
  assign ser = bus_kind_sel_hi && !bus_kind_sel_lo;
  assign tst = bus_kind_sel_hi && bus_kind_sel_lo;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);

  ////////////////////////////////////////////////////////////////////////////
  a_test_quiet: assert property (
    tst [*2] |-> bus_dev_oe == 8'h00 && !alert_oe)
    else $error("bus or alert driven in test mode");
  a_cs_idle: assert property (cs_n [*2] |-> bus_dev_oe == 8'h00)
    else $error("bus driven while deselected");
  a_ser_msb_only: assert property (
    ser && $past(ser) |-> bus_dev_oe[6:0] == 7'h00)
    else $error("serial mode drives more than bus msb");
  a_sdo_release: assert property (
    ser && $rose(cs_n) |=> bus_dev_oe == 8'h00)
    else $error("serial output not released after deselect");
  a_wr_no_drive: assert property (
    (par && !parallel_timing_style && !cs_n && read_strobe_n) [*2]
    |-> bus_dev_oe == 8'h00)
    else $error("bus driven without read strobe");
  a_rd_drive: assert property (
    (par && !parallel_timing_style && !cs_n && !read_strobe_n) [*2]
    |-> bus_dev_oe == 8'hff)
    else $error("bus not driven under read strobe");
  a_ds_mux_drive: assert property (
    (par && !bus_kind_sel_lo && parallel_timing_style && !cs_n
     && read_strobe_n && write_strobe_n) [*2] |-> bus_dev_oe == 8'hff)
    else $error("mux data strobe read not driven");
  a_ds_nonmux_drive: assert property (
    (par && bus_kind_sel_lo && parallel_timing_style && !cs_n
     && !read_strobe_n && write_strobe_n) [*2] |-> bus_dev_oe == 8'hff)
    else $error("nonmux data strobe read not driven");

  c_ser_end: cover property (ser && $rose(cs_n));
  c_test: cover property (tst [*2]);
  c_alert: cover property (alert_oe);
endmodule : qfhp_properties

`default_nettype wire

// ---- test/test_quad_framer_host_port.sv ----
/*
  Self-checking bench: host and device joined by the pin carrier.
  Assumes transceivers answer {unit, address} for any read.
*/
`timescale 1ns/1ps
`default_nettype none

module test_quad_framer_host_port;
  import qfhp_pkg::*;
  logic                     clk = 1'b0;
  logic                     rstn = 1'b0;
  logic [2:0]               sw_addr = 3'h0;
  logic [DW-1:0]            sw_wdata = 8'h00;
  logic                     sw_wr = 1'b0;
  logic                     sw_rd = 1'b0;
  logic [UNITS-1:0]         unit_alert = 4'h0;
  logic [DW-1:0]            sw_rdata, d, wd_seen, wd;
  logic [UNITS-1:0]         reg_we, we_seen;
  logic [AW-1:0]            reg_raddr, reg_waddr, wa_seen, a;
  logic [UNITS-1:0][DW-1:0] reg_rdata;
  logic [DW-1:0]            reg_wdata;
  logic [1:0]               u, k;
  int                       bad_count = 0;
  int                       check_count = 0;

  always #5 clk = ~clk;

  qfhp_if link_if ();
  qfhp_host #(.SER_TICK(1)) qfhp_host_inst (.clk(clk), .rstn(rstn),
    .link(link_if), .sw_addr(sw_addr), .sw_wdata(sw_wdata), .sw_wr(sw_wr),
    .sw_rd(sw_rd), .sw_rdata(sw_rdata));
  qfhp_device qfhp_device_inst (.clk(clk), .rstn(rstn), .link(link_if),
    .unit_alert(unit_alert), .reg_raddr(reg_raddr), .reg_rdata(reg_rdata),
    .reg_we(reg_we), .reg_waddr(reg_waddr), .reg_wdata(reg_wdata));
  qfhp_properties qfhp_properties_inst (.clk(clk), .rstn(rstn),
    .cs_n(link_if.cs_n), .bus_kind_sel_lo(link_if.bus_kind_sel_lo),
    .bus_kind_sel_hi(link_if.bus_kind_sel_hi),
    .parallel_timing_style(link_if.parallel_timing_style),
    .read_strobe_n(link_if.read_strobe_n),
    .write_strobe_n(link_if.write_strobe_n),
    .bus_dev_oe(link_if.bus_dev_oe), .alert_oe(link_if.alert_oe));

  ////////////////////////////////////////////////////////////////////////////
  // transceiver stand-ins
  always_comb
  begin
    for (int n = 0; n < UNITS; n++)
      reg_rdata[n] = {2'(n), reg_raddr};
  end

  always @(posedge clk)
  begin
    if (sw_wr && sw_addr == HR_CMD)
      we_seen <= '0;
    else if (|reg_we)
    begin
      we_seen <= reg_we;
      wa_seen <= reg_waddr;
      wd_seen <= reg_wdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  task summarize;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : summarize

  task chk(input logic [DW-1:0] got, input logic [DW-1:0] exp);
    check_count++;
    if (got !== exp)
    begin
      bad_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task wr(input logic [2:0] ad, input logic [DW-1:0] v);
    @(posedge clk);
    sw_addr  <= ad;
    sw_wdata <= v;
    sw_wr    <= 1'b1;
    @(posedge clk);
    sw_wr <= 1'b0;
  endtask : wr

  task rd(input logic [2:0] ad);
    @(posedge clk);
    sw_addr <= ad;
    sw_rd   <= 1'b1;
    @(posedge clk);
    sw_rd <= 1'b0;
    #1 d = sw_rdata;
  endtask : rd

  task run(input logic [DW-1:0] go);
    int n;
    n = 0;
    wr(HR_CMD, go);
    do
    begin
      rd(HR_STATUS);
      n++;
    end
    while (d[ST_DONE_BIT] !== 1'b1 && n < 3000);
    if (n >= 3000)
    begin
      bad_count++;
      summarize();
    end
  endtask : run

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    for (int i = 0; i < 12; i++)
    begin
      u  = 2'(i);
      k  = 2'(i / 4);
      wd = 8'h5a ^ 8'(i);
      a  = (k == K_SERIAL) ? {1'b0, 5'(i * 3)} : {1'b1, 5'(i * 5)};
      wr(HR_CTRL, {1'b0, u, i[1], i[0], i[0], k});
      wr(HR_ADDR, {2'b00, a});
      wr(HR_WDATA, wd);
      run(8'h01);
      chk(8'(we_seen), 8'(1 << u));
      chk({2'b00, wa_seen}, {2'b00, a});
      chk(wd_seen, wd);
      run(8'h02);
      chk(8'(we_seen), 8'h00);
      rd(HR_RDATA);
      chk(d, {u, a});
    end
    @(posedge clk) unit_alert <= 4'h4;
    repeat (3) @(posedge clk);
    chk(8'(link_if.alert_n), 8'h00);
    wr(HR_CTRL, 8'h03);
    repeat (3) @(posedge clk);
    chk(8'(link_if.alert_n), 8'h01);
    unit_alert <= 4'h0;
    wr(HR_CTRL, 8'h00);
    repeat (3) @(posedge clk);
    chk(8'(link_if.alert_n), 8'h01);
    summarize();
  end
endmodule : test_quad_framer_host_port

`default_nettype wire
